// [hdl/adc_seq_pkg.sv]
package adc_seq_pkg;

  // Avalon-MM slave geometry. Each register takes one aligned 32-bit word.
  localparam int          ADDR_W          = 10;
  localparam int          DATA_W          = 32;
  localparam int          BYTE_W          = 8;
  localparam int          RES_W           = 10;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  IDX_RESULT_LO   = 8'h78;
  localparam logic [7:0]  IDX_RESULT_HI   = 8'h79;
  localparam logic [7:0]  IDX_CTRL_A      = 8'h7A;
  localparam logic [7:0]  IDX_CTRL_B      = 8'h7B;
  localparam logic [7:0]  IDX_MUX         = 8'h7C;

  // converter_control_status_a fields.
  localparam int          CA_ENABLE       = 7;
  localparam int          CA_START        = 6;
  localparam int          CA_AUTO_TRIG    = 5;
  localparam int          CA_DONE_FLAG    = 4;
  localparam int          CA_IRQ_EN       = 3;
  localparam int          CA_PS_MSB       = 2;
  localparam int          CA_PS_LSB       = 0;

  // converter_control_status_b fields.
  localparam int          CB_TS_MSB       = 2;
  localparam int          CB_TS_LSB       = 0;

  // input_reference_select_register fields.
  localparam int          MX_REF_MSB      = 7;
  localparam int          MX_REF_LSB      = 6;
  localparam int          MX_LEFT_ALIGN   = 5;
  localparam int          MX_CH_MSB       = 3;
  localparam int          MX_CH_LSB       = 0;

  // Channel select codes.
  localparam logic [3:0]  CH_TEMP         = 4'h8;
  localparam logic [3:0]  CH_BANDGAP      = 4'hE;
  localparam logic [3:0]  CH_GROUND       = 4'hF;
  localparam int          NUM_EXT_CH      = 8;

  // Reference select codes; 2'h2 is reserved and selects nothing.
  localparam logic [1:0]  REF_EXT_PIN     = 2'h0;
  localparam logic [1:0]  REF_AVCC        = 2'h1;
  localparam logic [1:0]  REF_INTERNAL    = 2'h3;

  // Trigger source code for free running operation.
  localparam logic [2:0]  TS_FREE_RUN     = 3'h0;

  // Conversion lengths in converter clock cycles.
  localparam logic [4:0]  FIRST_CONV_CYC  = 5'h19;
  localparam logic [4:0]  NORMAL_CONV_CYC = 5'h0D;

  // Prescaler codes 000 and 001 both divide by two.
  localparam logic [2:0]  PS_MIN_SHIFT    = 3'h1;
  localparam int          DIV_CNT_W       = 7;

  // Reset values.
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [9:0]  RESET_RESULT    = 10'h000;

  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01
  } seq_state_t;

endpackage

// [hdl/conv_timing_if.sv]
`timescale 1ns/1ns

interface conv_timing_if;
  import adc_seq_pkg::*;

  logic       enable;
  logic       start;
  logic       first_conv;
  logic [2:0] prescale;
  logic       busy;
  logic       done;

  modport ctrl
  (
    output enable,
    output start,
    output first_conv,
    output prescale,
    input  busy,
    input  done
  );

  modport timer
  (
    input  enable,
    input  start,
    input  first_conv,
    input  prescale,
    output busy,
    output done
  );

endinterface

// [hdl/conv_timer.sv]
`timescale 1ns/1ns

module conv_timer
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic    sys_clk,
  input wire logic    reset_n,
  // Link to the register block
  conv_timing_if.timer tif
);

  typedef struct packed
  {
    seq_state_t           st;
    logic [DIV_CNT_W-1:0] div_cnt;
    logic [4:0]           cyc_cnt;
    logic [4:0]           cyc_len;
    logic                 done;
  } timer_state_t;

  timer_state_t r;
  timer_state_t r_nxt;

  logic [2:0]           shift;
  logic [DIV_CNT_W-1:0] div_last;
  logic                 tick;

  always_comb
  begin
    shift    = (tif.prescale < PS_MIN_SHIFT) ? PS_MIN_SHIFT : tif.prescale;
    div_last = DIV_CNT_W'((8'h01 << shift) - 8'h01);
    tick     = (r.div_cnt == div_last);
    r_nxt      = r;
    r_nxt.done = 1'b0;
    if (!tif.enable)
    begin
      // Switching off aborts a conversion and stops the prescaler.
      r_nxt.st      = SEQ_IDLE;
      r_nxt.div_cnt = '0;
      r_nxt.cyc_cnt = '0;
    end
    else
    begin
      r_nxt.div_cnt = tick ? '0 : DIV_CNT_W'(r.div_cnt + 1'b1);
      case (r.st)
        SEQ_IDLE:
        begin
          if (tif.start)
          begin
            r_nxt.st      = SEQ_CONV;
            r_nxt.cyc_cnt = '0;
            r_nxt.cyc_len = tif.first_conv ? FIRST_CONV_CYC : NORMAL_CONV_CYC;
          end
        end
        SEQ_CONV:
        begin
          if (tick)
          begin
            if (r.cyc_cnt == 5'(r.cyc_len - 5'h01))
            begin
              r_nxt.st   = SEQ_IDLE;
              r_nxt.done = 1'b1;
            end
            else
            begin
              r_nxt.cyc_cnt = 5'(r.cyc_cnt + 5'h01);
            end
          end
        end
        default:
        begin
          r_nxt.st = SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      r <= '{st: SEQ_IDLE, div_cnt: '0, cyc_cnt: '0, cyc_len: NORMAL_CONV_CYC, done: 1'b0};
    end
    else
    begin
      r <= r_nxt;
    end
  end

  assign tif.busy = (r.st == SEQ_CONV);
  assign tif.done = r.done;

endmodule

// [hdl/adc_sequencer_registers.sv]
`timescale 1ns/1ns

module adc_sequencer_registers
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]   address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [DATA_W-1:0]   writedata,
  input  wire logic [DATA_W/8-1:0] byteenable,
  output logic      [DATA_W-1:0]   readdata,
  output logic                     waitrequest,
  // Analog converter core
  input  wire logic [RES_W-1:0]    conv_data,
  output logic                     converter_on,
  output logic                     conv_busy,
  output logic [NUM_EXT_CH-1:0]    ext_input_sel,
  output logic                     temp_sensor_en,
  output logic                     bandgap_sel,
  output logic                     ground_sel,
  output logic                     ref_ext_sel,
  output logic                     ref_avcc_sel,
  output logic                     int_ref_on,
  // Processor core and trigger sources
  input  wire logic                global_irq_en,
  input  wire logic                irq_ack,
  input  wire logic [7:1]          trigger_in,
  output logic                     irq_req
);

  typedef struct packed
  {
    // Software-visible control state.
    logic                  enable;
    logic                  start;
    logic                  auto_trig;
    logic                  done_flag;
    logic                  irq_en;
    logic [2:0]            prescale;
    logic [2:0]            trig_src;
    logic [1:0]            ref_sel;
    logic                  left_align;
    logic [3:0]            chan_sel;
    // Converter-side state.
    logic [RES_W-1:0]      result;
    logic                  locked;
    logic                  first_pending;
    logic                  trig_prev;
    // Selection in force for the running conversion.
    logic [1:0]            act_ref;
    logic [3:0]            act_chan;
    logic [NUM_EXT_CH-1:0] ext_hot;
    logic                  temp_on;
    logic                  bg_on;
    logic                  gnd_on;
    // Bus answer.
    logic                  rd_ack;
    logic [DATA_W-1:0]     rdata;
  } regs_state_t;

  regs_state_t r;
  regs_state_t r_nxt;

  conv_timing_if tif ();

  conv_timer u_conv_timer
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tif     (tif.timer)
  );

  logic [7:0]            reg_idx;
  logic                  wr_en;
  logic                  rd_accept;
  logic [7:0]            wbyte;
  logic [7:0]            res_lo;
  logic [7:0]            res_hi;
  logic [7:0]            rd_byte;
  logic                  trig_sel;
  logic                  free_run;
  logic [NUM_EXT_CH-1:0] cand_hot;

  // One-hot decode of the written channel code for the external inputs.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT_CH; gi++)
    begin : g_ext_hot
      assign cand_hot[gi] = (r.chan_sel == 4'(gi));
    end
  endgenerate

  // Reads take one wait state so that the answer comes from a register.
  assign waitrequest = read && !r.rd_ack;

  always_comb
  begin
    reg_idx   = address[ADDR_W-1:2];
    wbyte     = writedata[BYTE_W-1:0];
    wr_en     = write && byteenable[0];
    rd_accept = read && r.rd_ack;
    free_run  = r.auto_trig && (r.trig_src == TS_FREE_RUN);

    // The alignment bit acts on the view, not on the stored result.
    if (r.left_align)
    begin
      res_hi = r.result[RES_W-1:2];
      res_lo = {r.result[1:0], 6'h00};
    end
    else
    begin
      res_hi = {6'h00, r.result[RES_W-1:8]};
      res_lo = r.result[7:0];
    end

    case (reg_idx)
      IDX_RESULT_LO: rd_byte = res_lo;
      IDX_RESULT_HI: rd_byte = res_hi;
      IDX_CTRL_A:    rd_byte = {r.enable, r.start, r.auto_trig, r.done_flag,
                                r.irq_en, r.prescale};
      IDX_CTRL_B:    rd_byte = {5'h00, r.trig_src};
      IDX_MUX:       rd_byte = {r.ref_sel, r.left_align, 1'b0, r.chan_sel};
      default:       rd_byte = RESET_BYTE;
    endcase

    // Code 000 selects no edge source, so switching to it cannot trigger.
    trig_sel = (r.trig_src == TS_FREE_RUN) ? 1'b0 : trigger_in[r.trig_src];

    r_nxt           = r;
    r_nxt.trig_prev = trig_sel;

    // Bus read answer and the side effects of an accepted read.
    r_nxt.rd_ack = read && !r.rd_ack;
    if (read && !r.rd_ack)
    begin
      r_nxt.rdata = {24'h000000, rd_byte};
    end
    // The lock starts at the edge that captures the low byte, so a completion in that
    // same cycle cannot pair a new high byte with an old low byte.
    if (read && !r.rd_ack && (reg_idx == IDX_RESULT_LO))
    begin
      r_nxt.locked = 1'b1;
    end
    if (rd_accept && (reg_idx == IDX_RESULT_HI))
    begin
      r_nxt.locked = 1'b0;
    end

    // Register writes.
    if (wr_en)
    begin
      case (reg_idx)
        IDX_CTRL_A:
        begin
          r_nxt.enable    = wbyte[CA_ENABLE];
          r_nxt.auto_trig = wbyte[CA_AUTO_TRIG];
          r_nxt.irq_en    = wbyte[CA_IRQ_EN];
          r_nxt.prescale  = wbyte[CA_PS_MSB:CA_PS_LSB];
          if (wbyte[CA_ENABLE] && !r.enable)
          begin
            r_nxt.first_pending = 1'b1;
          end
          // Only a one starts; a zero never stops a conversion.
          if (wbyte[CA_START] && wbyte[CA_ENABLE])
          begin
            r_nxt.start = 1'b1;
          end
          if (wbyte[CA_DONE_FLAG])
          begin
            r_nxt.done_flag = 1'b0;
          end
        end
        IDX_CTRL_B:
        begin
          r_nxt.trig_src = wbyte[CB_TS_MSB:CB_TS_LSB];
        end
        IDX_MUX:
        begin
          r_nxt.ref_sel    = wbyte[MX_REF_MSB:MX_REF_LSB];
          r_nxt.left_align = wbyte[MX_LEFT_ALIGN];
          r_nxt.chan_sel   = wbyte[MX_CH_MSB:MX_CH_LSB];
        end
        default:
        begin
          r_nxt.rdata = r_nxt.rdata;
        end
      endcase
    end

    // Hardware clear when the interrupt vector runs.
    if (irq_ack)
    begin
      r_nxt.done_flag = 1'b0;
    end

    // Auto trigger on a rising edge of the chosen source.
    if (r.enable && r.auto_trig && trig_sel && !r.trig_prev && !r.start)
    begin
      r_nxt.start = 1'b1;
    end

    // The first conversion is consumed once the timer takes the start.
    if (tif.start && !tif.busy)
    begin
      r_nxt.first_pending = 1'b0;
    end

    // Completion: flag and, unless locked, result in the same cycle; the start bit clears unless free running.
    if (tif.done)
    begin
      r_nxt.done_flag = 1'b1;
      if (!r_nxt.locked)
      begin
        r_nxt.result = conv_data;
      end
      r_nxt.start = free_run;
    end

    // A new selection takes hold only between conversions.
    if (!r.start || tif.done)
    begin
      r_nxt.act_ref  = r.ref_sel;
      r_nxt.act_chan = r.chan_sel;
      r_nxt.ext_hot  = r.chan_sel[3] ? '0 : cand_hot;
      r_nxt.temp_on  = (r.chan_sel == CH_TEMP);
      r_nxt.bg_on    = (r.chan_sel == CH_BANDGAP);
      r_nxt.gnd_on   = (r.chan_sel == CH_GROUND);
    end

    // Switching off wins over every start source and aborts the conversion.
    if (!r_nxt.enable)
    begin
      r_nxt.start         = 1'b0;
      r_nxt.first_pending = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= r_nxt;
    end
  end

  // The timer must not see the old start in the cycle its done pulse stands,
  // or a single conversion would run twice.
  assign tif.enable     = r.enable;
  assign tif.start      = r.start && !tif.done;
  assign tif.first_conv = r.first_pending;
  assign tif.prescale   = r.prescale;

  assign readdata       = r.rdata;
  assign converter_on   = r.enable;
  assign conv_busy      = tif.busy;
  assign ext_input_sel  = r.ext_hot;
  assign temp_sensor_en = r.temp_on;
  assign bandgap_sel    = r.bg_on;
  assign ground_sel     = r.gnd_on;
  assign ref_ext_sel    = (r.act_ref == REF_EXT_PIN);
  assign ref_avcc_sel   = (r.act_ref == REF_AVCC);
  assign int_ref_on     = (r.act_ref == REF_INTERNAL);
  assign irq_req        = r.done_flag && r.irq_en && global_irq_en;

endmodule

// [testbench/conv_model.sv]
`timescale 1ns/1ns

module conv_model
  import adc_seq_pkg::*;
(
  // Clock and core state
  input  wire logic             sys_clk,
  input  wire logic             converter_on,
  // Code the bench wants converted
  input  wire logic [RES_W-1:0] sample,
  output logic      [RES_W-1:0] conv_data
);
  logic [RES_W-1:0] noise_r = 10'h155;

  // A core that is off gives no settled code, so a load from it must not match.
  always_ff @(posedge sys_clk)
    noise_r <= ~noise_r;
  assign conv_data = converter_on ? sample : noise_r;
endmodule

// [testbench/adc_sequencer_registers_asserts.sv]
`timescale 1ns/1ns

module adc_sequencer_registers_asserts
  import adc_seq_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  reset_n,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic                  waitrequest,
  input wire logic [DATA_W-1:0]     readdata,
  input wire logic                  converter_on,
  input wire logic                  conv_busy,
  input wire logic [NUM_EXT_CH-1:0] ext_input_sel,
  input wire logic                  temp_sensor_en,
  input wire logic                  bandgap_sel,
  input wire logic                  ground_sel,
  input wire logic                  ref_ext_sel,
  input wire logic                  ref_avcc_sel,
  input wire logic                  int_ref_on,
  input wire logic                  global_irq_en,
  input wire logic                  irq_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_write_no_wait: assert property (write |-> !waitrequest)
    else $error("write stalled");
  a_read_one_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read wait state count wrong");
  a_read_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_irq_global_off: assert property (!global_irq_en |-> !irq_req)
    else $error("irq without global enable");
  a_ref_one_hot: assert property ($onehot0({ref_ext_sel, ref_avcc_sel, int_ref_on}))
    else $error("two references selected");
  a_temp_exclusive: assert property (temp_sensor_en |-> ext_input_sel == 8'h00 && !bandgap_sel && !ground_sel)
    else $error("temp channel shares the input");
  a_chan_held_busy: assert property (conv_busy && $past(conv_busy) && $past(conv_busy, 2) |-> $stable({ext_input_sel, temp_sensor_en, bandgap_sel, ground_sel}))
    else $error("channel changed mid conversion");
  a_ref_held_busy: assert property (conv_busy && $past(conv_busy) && $past(conv_busy, 2) |-> $stable({ref_ext_sel, ref_avcc_sel, int_ref_on}))
    else $error("reference changed mid conversion");
  a_off_no_busy: assert property (!converter_on [*3] |-> !conv_busy)
    else $error("busy while switched off");
endmodule

bind adc_sequencer_registers adc_sequencer_registers_asserts i_adc_sequencer_registers_asserts
(
  .sys_clk(sys_clk), .reset_n(reset_n), .read(read), .write(write),
  .waitrequest(waitrequest), .readdata(readdata), .converter_on(converter_on),
  .conv_busy(conv_busy), .ext_input_sel(ext_input_sel), .temp_sensor_en(temp_sensor_en),
  .bandgap_sel(bandgap_sel), .ground_sel(ground_sel), .ref_ext_sel(ref_ext_sel),
  .ref_avcc_sel(ref_avcc_sel), .int_ref_on(int_ref_on), .global_irq_en(global_irq_en),
  .irq_req(irq_req)
);

// [testbench/adc_sequencer_registers_tb_top.sv]
`timescale 1ns/1ns

module adc_sequencer_registers_tb_top;
  import adc_seq_pkg::*;
  logic              sys_clk, reset_n, read, write, waitrequest;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata;
  logic [3:0]        byteenable;
  logic [RES_W-1:0]  conv_data, sample;
  logic              converter_on, conv_busy, temp_sensor_en, bandgap_sel, ground_sel;
  logic              ref_ext_sel, ref_avcc_sel, int_ref_on, global_irq_en, irq_ack, irq_req;
  logic [7:0]        ext_input_sel, rd;
  logic [7:1]        trigger_in;
  int                fail_count = 0, compares = 0, run_len = 0, last_len = 0;
  logic [7:0]        regs [6] = '{IDX_RESULT_LO, IDX_RESULT_HI, IDX_CTRL_A, IDX_CTRL_B, IDX_MUX, 8'h40};

  adc_sequencer_registers i_adc_sequencer_registers
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .conv_data(conv_data), .converter_on(converter_on),
    .conv_busy(conv_busy), .ext_input_sel(ext_input_sel), .temp_sensor_en(temp_sensor_en),
    .bandgap_sel(bandgap_sel), .ground_sel(ground_sel), .ref_ext_sel(ref_ext_sel),
    .ref_avcc_sel(ref_avcc_sel), .int_ref_on(int_ref_on), .global_irq_en(global_irq_en),
    .irq_ack(irq_ack), .trigger_in(trigger_in), .irq_req(irq_req)
  );
  conv_model i_conv_model (.sys_clk(sys_clk), .converter_on(converter_on), .sample(sample),
                           .conv_data(conv_data));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (conv_busy === 1'b1)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      last_len <= run_len;
      run_len <= 0;
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic rnw, input logic [7:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, d};
    read <= rnw;
    write <= !rnw;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0)
      @(posedge sys_clk);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wait_flag();
    rd = 8'h00;
    while (rd[4] !== 1'b1)
      bus(1'b1, IDX_CTRL_A, 8'h00);
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    {reset_n, read, write, irq_ack, global_irq_en, trigger_in} = '0;
    address = '0;
    writedata = '0;
    byteenable = 4'hF;
    sample = 10'h2A5;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, regs[i], 8'h00);
      chk("reset value", 16'h0000, {8'h00, rd});
    end
    chk("ref after reset", 16'h0001, {15'h0, ref_ext_sel});
    for (int c = 0; c < 16; c++)
    begin
      bus(1'b0, IDX_MUX, {c[1:0], 2'b00, c[3:0]});
      repeat (3) @(posedge sys_clk);
      chk("channel", (c < 8) ? 16'(1 << c) : 16'h0000, {8'h00, ext_input_sel});
      chk("special", {13'h0, c == 8, c == 14, c == 15}, {13'h0, temp_sensor_en, bandgap_sel, ground_sel});
      chk("reference", {13'h0, c[1:0] == 0, c[1:0] == 1, c[1:0] == 3}, {13'h0, ref_ext_sel, ref_avcc_sel, int_ref_on});
    end
    global_irq_en <= 1'b1;
    bus(1'b0, IDX_MUX, 8'hC8);
    bus(1'b0, IDX_CTRL_A, 8'hC8);
    bus(1'b0, IDX_MUX, 8'h40);
    bus(1'b0, IDX_CTRL_A, 8'h88);
    bus(1'b1, IDX_CTRL_A, 8'h00);
    chk("start held", 16'h0001, {15'h0, rd[6]});
    chk("selection held", 16'h0003, {14'h0, temp_sensor_en, int_ref_on});
    wait_flag();
    chk("done status", 16'h0098, {8'h00, rd});
    chk("first length", 16'h0001, {15'h0, last_len >= 48 && last_len <= 54});
    chk("selection applied", 16'h0102, {ext_input_sel, 5'h0, temp_sensor_en, ref_avcc_sel, int_ref_on});
    chk("irq on", 16'h0001, {15'h0, irq_req});
    global_irq_en <= 1'b0;
    @(posedge sys_clk);
    chk("irq masked", 16'h0000, {15'h0, irq_req});
    global_irq_en <= 1'b1;
    bus(1'b1, IDX_RESULT_LO, 8'h00);
    chk("low right", 16'h00A5, {8'h00, rd});
    bus(1'b1, IDX_RESULT_HI, 8'h00);
    chk("high right", 16'h0002, {8'h00, rd});
    bus(1'b0, IDX_MUX, 8'h60);
    bus(1'b1, IDX_RESULT_LO, 8'h00);
    chk("low left", 16'h0040, {8'h00, rd});
    bus(1'b1, IDX_RESULT_HI, 8'h00);
    chk("high left", 16'h00A9, {8'h00, rd});
    bus(1'b0, IDX_MUX, 8'h40);
    bus(1'b0, IDX_CTRL_A, 8'h88);
    bus(1'b1, IDX_CTRL_A, 8'h00);
    chk("flag zero write", 16'h0098, {8'h00, rd});
    bus(1'b1, IDX_RESULT_LO, 8'h00);
    sample <= 10'h13C;
    bus(1'b0, IDX_CTRL_A, 8'hD8);
    wait_flag();
    chk("normal length", 16'h0001, {15'h0, last_len >= 24 && last_len <= 30});
    bus(1'b1, IDX_RESULT_HI, 8'h00);
    chk("locked result", 16'h0002, {8'h00, rd});
    irq_ack <= 1'b1;
    @(posedge sys_clk);
    irq_ack <= 1'b0;
    bus(1'b1, IDX_CTRL_A, 8'h00);
    chk("flag acked", 16'h0088, {8'h00, rd});
    bus(1'b0, IDX_CTRL_A, 8'hC8);
    wait_flag();
    bus(1'b1, IDX_RESULT_LO, 8'h00);
    chk("new low", 16'h003C, {8'h00, rd});
    bus(1'b1, IDX_RESULT_HI, 8'h00);
    chk("new high", 16'h0001, {8'h00, rd});
    bus(1'b0, IDX_CTRL_A, 8'h98);
    bus(1'b0, IDX_CTRL_A, 8'hC8);
    bus(1'b0, IDX_CTRL_A, 8'h00);
    repeat (60) @(posedge sys_clk);
    bus(1'b1, IDX_CTRL_A, 8'h00);
    chk("aborted", 16'h0000, {7'h0, rd, converter_on});
    bus(1'b0, IDX_CTRL_A, 8'hCB);
    wait_flag();
    chk("divide by 8", 16'h0001, {15'h0, last_len >= 190 && last_len <= 215});
    bus(1'b0, IDX_CTRL_A, 8'hB8);
    bus(1'b0, IDX_CTRL_B, 8'h02);
    trigger_in[2] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("triggered", 16'h0001, {15'h0, conv_busy});
    trigger_in[2] <= 1'b0;
    wait_flag();
    bus(1'b0, IDX_CTRL_B, 8'h00);
    repeat (6) @(posedge sys_clk);
    chk("no free run trigger", 16'h0000, {15'h0, conv_busy});
    bus(1'b0, IDX_CTRL_A, 8'hF8);
    wait_flag();
    bus(1'b0, IDX_CTRL_A, 8'hB8);
    wait_flag();
    chk("free running", 16'h00F8, {8'h00, rd});
    bus(1'b0, IDX_CTRL_A, 8'h00);
    summarize();
  end
endmodule
